// >>> hdl/rdsga_params.svh
`ifndef RDSGA_PARAMS_SVH
`define RDSGA_PARAMS_SVH

// ----------------------------------------------------------------------------
// Group geometry
// ----------------------------------------------------------------------------
`define RDSGA_GROUP_BITS  104
`define RDSGA_BLK_BITS    26
`define RDSGA_INFO_BITS   16
`define RDSGA_CHK_BITS    10
`define RDSGA_BLK_LAST    5'h19
`define RDSGA_BLK_MAX     2'h3

// ----------------------------------------------------------------------------
// Checkword generator and block offsets
// ----------------------------------------------------------------------------
`define RDSGA_POLY        10'h1B9
`define RDSGA_OFS_A       10'h0FC
`define RDSGA_OFS_B       10'h198
`define RDSGA_OFS_C       10'h168
`define RDSGA_OFS_CP      10'h350
`define RDSGA_OFS_D       10'h1B4

// ----------------------------------------------------------------------------
// Block 2 field positions
// ----------------------------------------------------------------------------
`define RDSGA_VER_BIT     11
`define RDSGA_TP_BIT      10
`define RDSGA_PTY_LSB     5

// ----------------------------------------------------------------------------
// Name group filler and user lists
// ----------------------------------------------------------------------------
`define RDSGA_AF_FILL     16'hE0CD
`define RDSGA_LIST_DEPTH  4
`define RDSGA_FIFO_DEPTH  8
`define RDSGA_USER_BITS   48
`define RDSGA_SLOTS       8

// ----------------------------------------------------------------------------
// Bit timing: rate in milli-bits per second, clock in Hz
// ----------------------------------------------------------------------------
`define RDSGA_CLK_HZ      250000000
`define RDSGA_RATE_MBPS   1187500
`define RDSGA_BIT_CYCLES  (64'd`RDSGA_CLK_HZ * 64'd1000 / 64'd`RDSGA_RATE_MBPS)

`endif

// >>> hdl/rdsga_pkg.sv
// ----------------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------------
package rdsga_pkg;
	// Serializer state
	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} rdsga_state_t;

	// Source chosen by one slot of the sequence
	typedef enum logic [1:0] {
		SLOT_NAME,
		SLOT_LIST_FIRST,
		SLOT_LIST_SECOND,
		SLOT_SPARE
	} rdsga_slot_t;
endpackage : rdsga_pkg

// >>> hdl/rdsga_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Flip-flop FIFO with valid and ready on both sides
// ----------------------------------------------------------------------------
module rdsga_fifo #(
	parameter int WIDTH = 49,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];     // Storage
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [AW-1:0]    wr_ff, nxt_wr;      // Write index
	logic [AW-1:0]    rd_ff, nxt_rd;      // Read index
	logic [AW:0]      cnt_ff, nxt_cnt;    // Fill level
	logic             push, pop;

	// Honest flags straight from the fill level
	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next pointers, level and storage
	always_comb begin
		nxt_mem = mem_ff;
		nxt_wr  = wr_ff;
		nxt_rd  = rd_ff;
		nxt_cnt = cnt_ff;
		if (push) begin
			nxt_mem[wr_ff] = in_data;
			nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
		mem_ff <= nxt_mem;
	end
endmodule : rdsga_fifo

`default_nettype wire

// >>> hdl/rdsga_assembler.sv
// Behaviour
// [R1] Group is 104 bits, four 26-bit blocks
// [R2] Block is 16 info bits plus 10-bit checkword
// [R3] Everything is sent most significant bit first
// [R4] Blocks and groups follow with no gaps
// [R5] Bits leave at 1187.5 bits per second
// [R6] Block 2 top four bits hold type
// [R7] Block 2 fifth bit selects version
// [R8] Version B repeats identifier in block 3
// [R9] Block 1 always carries the identifier
// [R10] Checkword and offset are computed internally
// [R11] Traffic and programme type ORed into block 2
// [R12] Transparent data groups map user words directly
// [R13] In-house groups map user words directly
// [R14] Identification 3A groups map user words directly
// [R15] Provider supplies 3A type and identifier
// [R16] User lists are retransmitted cyclically
// [R17] Configured sequence orders any group types
// [R18] Name sent over four consecutive name groups
// [R19] Checkword uses standard polynomial plus offset
`timescale 1ns/1ps
`default_nettype none
`include "rdsga_params.svh"

module rdsga_assembler #(
	parameter int BIT_CYCLES = int'(`RDSGA_BIT_CYCLES)    // Clocks per bit
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        tx_enable,
	input  wire logic [15:0] pi_code,
	input  wire logic        tp_flag,
	input  wire logic [4:0]  pty_code,
	input  wire logic [63:0] ps_name,
	input  wire logic [15:0] seq_slots,
	input  wire logic        user_valid,
	output logic             user_ready,
	input  wire logic        user_list,
	input  wire logic [47:0] user_group,
	input  wire logic [1:0]  list_clear,
	output logic             rds_bit,
	output logic             rds_bit_valid,
	output logic             group_start
);
	localparam int LD = `RDSGA_LIST_DEPTH;
	// ------------------------------------------------------------------------
	// Checkword: remainder of word times x^10 over the generator
	// ------------------------------------------------------------------------
	function automatic logic [9:0] rdsga_chk(input logic [15:0] w);
		logic [9:0] r;
		logic       fb;
		r = '0;
		for (int i = 15; i >= 0; i--) begin
			fb = w[i] ^ r[9];
			r  = {r[8:0], 1'b0};
			if (fb) begin
				r = r ^ `RDSGA_POLY;    // R19
			end
		end
		return r;
	endfunction : rdsga_chk
	// ------------------------------------------------------------------------
	// Input FIFO and user group lists
	// ------------------------------------------------------------------------
	logic        f_valid;               // FIFO holds an entry
	logic        f_ready;               // Target list can take it
	logic [48:0] f_data;                // {list select, group}
	logic [1:0]  list_has;              // List not empty
	logic [1:0]  list_room;             // List not full
	logic [47:0] list_word [2];         // Entry at read pointer
	logic [1:0]  list_take;             // Advance read pointer
	rdsga_fifo #(
		.WIDTH (`RDSGA_USER_BITS + 1),
		.DEPTH (`RDSGA_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (user_valid),
		.in_ready  (user_ready),
		.in_data   ({user_list, user_group}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);
	// A full list stalls the FIFO, which then back-pressures the source
	assign f_ready = list_room[f_data[48]];
	for (genvar g = 0; g < 2; g++) begin : g_list
		logic [47:0] mem_ff [LD];          // Stored groups
		logic [47:0] nxt_mem [LD];
		logic [2:0]  cnt_ff, nxt_cnt;      // Entries stored
		logic [1:0]  rd_ff, nxt_rd;        // Next entry to send
		logic        wr;
		assign wr           = f_valid && f_ready && (f_data[48] == 1'(g));
		assign list_has[g]  = (cnt_ff != 3'h0);
		assign list_room[g] = (cnt_ff != 3'(LD)) && !list_clear[g];
		assign list_word[g] = mem_ff[rd_ff];
		// Append, cycle and clear
		always_comb begin
			nxt_mem = mem_ff;
			nxt_cnt = cnt_ff;
			nxt_rd  = rd_ff;
			if (list_clear[g]) begin
				nxt_cnt = 3'h0;
				nxt_rd  = 2'h0;
			end else begin
				if (wr) begin
					nxt_mem[cnt_ff[1:0]] = f_data[47:0];
					nxt_cnt = cnt_ff + 3'h1;
				end
				if (list_take[g]) begin
					// Wrap to the first entry: endless repetition
					nxt_rd = ({1'b0, rd_ff} == cnt_ff - 3'h1) ? 2'h0 : rd_ff + 2'h1;    // R16
				end
			end
		end
		// Registers only
		always_ff @(posedge clk) begin
			if (rst) begin
				cnt_ff <= 3'h0;
				rd_ff  <= 2'h0;
			end else begin
				cnt_ff <= nxt_cnt;
				rd_ff  <= nxt_rd;
			end
			mem_ff <= nxt_mem;
		end
	end
	// ------------------------------------------------------------------------
	// Next group selection and assembly
	// ------------------------------------------------------------------------
	rdsga_pkg::rdsga_slot_t slot;        // Source of the next group
	logic [2:0]  slot_ff, nxt_slot;      // Sequence position
	logic [1:0]  seg_ff, nxt_seg;        // Name segment
	logic [47:0] src;                    // Raw blocks 2 to 4
	logic [15:0] nb2, nb3, nb4;          // Assembled blocks 2 to 4
	logic [15:0] b2_ff, b3_ff, b4_ff;    // Group on air
	logic [15:0] nxt_b2, nxt_b3, nxt_b4;
	logic        load_grp;               // Commit next group
	logic        use_name;
	assign slot = rdsga_pkg::rdsga_slot_t'(seq_slots[{slot_ff, 1'b0} +: 2]);    // R17
	// Pick the source; empty list falls back to a name group
	always_comb begin
		use_name  = 1'b0;
		list_take = 2'b00;
		if (slot == rdsga_pkg::SLOT_LIST_FIRST && list_has[0]) begin
			src = list_word[0];
			list_take[0] = load_grp;
		end else if (slot == rdsga_pkg::SLOT_LIST_SECOND && list_has[1]) begin
			src = list_word[1];
			list_take[1] = load_grp;
		end else begin
			use_name = 1'b1;
			// Type 0A, segment address in the low bits, two characters
			src = {11'h000, 3'h0, seg_ff, `RDSGA_AF_FILL, ps_name[{~seg_ff, 4'h0} +: 16]};    // R18
		end
		// User words land as typed: 5A, 6A, 3A pass through; 5B and 6B take the identifier in block 3
		nb2 = src[47:32] | {5'h00, tp_flag, pty_code, 5'h00};    // R6 R7 R11 R12 R13 R14
		nb3 = nb2[`RDSGA_VER_BIT] ? pi_code : src[31:16];        // R8
		nb4 = src[15:0];
	end
	// Advance the sequence when a group is committed
	always_comb begin
		nxt_slot = slot_ff;
		nxt_seg  = seg_ff;
		nxt_b2   = b2_ff;
		nxt_b3   = b3_ff;
		nxt_b4   = b4_ff;
		if (load_grp) begin
			nxt_slot = slot_ff + 3'h1;
			nxt_b2   = nb2;
			nxt_b3   = nb3;
			nxt_b4   = nb4;
			if (use_name) begin
				nxt_seg = seg_ff + 2'h1;    // R18
			end
		end
	end
	// Registers only
	always_ff @(posedge clk) begin
		if (rst) begin
			slot_ff <= 3'h0;
			seg_ff  <= 2'h0;
			b2_ff   <= 16'h0000;
			b3_ff   <= 16'h0000;
			b4_ff   <= 16'h0000;
		end else begin
			slot_ff <= nxt_slot;
			seg_ff  <= nxt_seg;
			b2_ff   <= nxt_b2;
			b3_ff   <= nxt_b3;
			b4_ff   <= nxt_b4;
		end
	end

	// ------------------------------------------------------------------------
	// Bit timing and serializer
	// ------------------------------------------------------------------------
	rdsga_pkg::rdsga_state_t state_ff, nxt_state;
	logic [17:0] div_ff, nxt_div;        // Clocks into current bit
	logic [4:0]  bit_ff, nxt_bit;        // Bit within block
	logic [1:0]  blk_ff, nxt_blk;        // Block within group
	logic [25:0] shr_ff, nxt_shr;        // Block being shifted
	logic        out_ff, nxt_out;
	logic        vld_ff, nxt_vld;
	logic        gst_ff, nxt_gst;
	logic        tick;                   // End of a bit period
	logic [15:0] nword;                  // Next block's information word
	logic [9:0]  nofs;                   // Next block's offset
	assign tick = (state_ff == rdsga_pkg::ST_RUN) && (div_ff == 18'(BIT_CYCLES - 1));    // R5
	// Information word and offset of the block after the current one
	always_comb begin
		case (blk_ff)
			2'h0: begin
				nword = b2_ff;
				nofs  = `RDSGA_OFS_B;
			end
			2'h1: begin
				nword = b3_ff;
				nofs  = b2_ff[`RDSGA_VER_BIT] ? `RDSGA_OFS_CP : `RDSGA_OFS_C;
			end
			2'h2: begin
				nword = b4_ff;
				nofs  = `RDSGA_OFS_D;
			end
			default: begin
				nword = pi_code;    // R9
				nofs  = `RDSGA_OFS_A;
			end
		endcase
	end
	// Sequencing of bits, blocks and groups
	always_comb begin
		nxt_state = state_ff;
		nxt_div   = div_ff;
		nxt_bit   = bit_ff;
		nxt_blk   = blk_ff;
		nxt_shr   = shr_ff;
		nxt_out   = out_ff;
		nxt_vld   = 1'b0;
		nxt_gst   = 1'b0;
		load_grp  = 1'b0;
		case (state_ff)
			rdsga_pkg::ST_IDLE: begin
				nxt_out = 1'b0;
				if (tx_enable) begin
					// First block of the first group
					load_grp  = 1'b1;
					nxt_shr   = {pi_code, rdsga_chk(pi_code) ^ `RDSGA_OFS_A};    // R9 R10
					nxt_div   = 18'h00000;
					nxt_bit   = 5'h00;
					nxt_blk   = 2'h0;
					nxt_state = rdsga_pkg::ST_RUN;
				end
			end
			default: begin
				nxt_div = tick ? 18'h00000 : div_ff + 18'h00001;
				if (tick) begin
					nxt_out = shr_ff[25];    // R3
					nxt_vld = 1'b1;
					nxt_gst = (bit_ff == 5'h00) && (blk_ff == 2'h0);
					nxt_shr = {shr_ff[24:0], 1'b0};
					nxt_bit = bit_ff + 5'h01;
					if (bit_ff == `RDSGA_BLK_LAST) begin
						// Next block loads at once, no idle bit
						nxt_bit = 5'h00;
						nxt_blk = blk_ff + 2'h1;                          // R1
						nxt_shr = {nword, rdsga_chk(nword) ^ nofs};      // R2 R4 R10 R19
						if (blk_ff == `RDSGA_BLK_MAX) begin
							load_grp = tx_enable;                        // R4
							if (!tx_enable) begin
								nxt_state = rdsga_pkg::ST_IDLE;
							end
						end
					end
				end
			end
		endcase
	end
	// Registers only
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= rdsga_pkg::ST_IDLE;
			div_ff   <= 18'h00000;
			bit_ff   <= 5'h00;
			blk_ff   <= 2'h0;
			shr_ff   <= 26'h0000000;
			out_ff   <= 1'b0;
			vld_ff   <= 1'b0;
			gst_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			div_ff   <= nxt_div;
			bit_ff   <= nxt_bit;
			blk_ff   <= nxt_blk;
			shr_ff   <= nxt_shr;
			out_ff   <= nxt_out;
			vld_ff   <= nxt_vld;
			gst_ff   <= nxt_gst;
		end
	end
	assign rds_bit       = out_ff;
	assign rds_bit_valid = vld_ff;
	assign group_start   = gst_ff;
	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_block_end;
		tick && bit_ff == `RDSGA_BLK_LAST;
	endsequence
	sequence s_group_end;
		s_block_end ##0 (blk_ff == 2'h3);
	endsequence
	a_bit_bound: assert property (state_ff == rdsga_pkg::ST_RUN |-> bit_ff <= `RDSGA_BLK_LAST)    // R1
		else $error("bit index passed block end");
	a_block_wrap: assert property (s_group_end |=> blk_ff == 2'h0 && bit_ff == 5'h00)    // R1
		else $error("group did not end after four blocks");
	a_check_word: assert property (s_block_end |=> shr_ff[9:0] == (rdsga_chk(shr_ff[25:10]) ^ $past(nofs)))    // R2
		else $error("checkword or offset wrong");
	a_msb_first: assert property (tick |=> rds_bit == $past(shr_ff[25]) && rds_bit_valid)    // R3
		else $error("serial bit not taken from block top");
	a_no_gap: assert property (s_group_end ##0 tx_enable |=> state_ff == rdsga_pkg::ST_RUN && shr_ff[25:10] == $past(pi_code))    // R4
		else $error("gap or wrong first block between groups");
	a_bit_spacing: assert property (tick |=> !tick [*8])    // R5
		else $error("bit period too short");
	a_type_ver: assert property (load_grp |=> b2_ff[15:11] == $past(src[47:43]))    // R6 R7
		else $error("type or version not carried");
	a_verb_pi: assert property (load_grp && nb2[`RDSGA_VER_BIT] |=> b3_ff == $past(pi_code))    // R8
		else $error("version B block 3 lacks identifier");
	a_tp_pty: assert property (load_grp |=> (b2_ff[10:5] & $past({tp_flag, pty_code})) == $past({tp_flag, pty_code}))    // R11
		else $error("traffic or programme type bits missing");
	a_list_cycle: assert property (list_take[0] && {1'b0, g_list[0].rd_ff} == g_list[0].cnt_ff - 3'h1    // R16
		&& !list_clear[0] |=> g_list[0].rd_ff == 2'h0)
		else $error("first list did not wrap");
endmodule : rdsga_assembler

`default_nettype wire

// >>> dv/rdsga_modem_sink.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Modulator side: gathers the serial stream into whole groups
// ----------------------------------------------------------------------------
module rdsga_modem_sink #(
	parameter int BIT_CYCLES = 16	// Clocks per bit
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         rds_bit,
	input  wire logic         rds_bit_valid,
	input  wire logic         group_start,
	output logic      [103:0] grp_bits,
	output logic              grp_done,
	output logic              gap_bad
);
	int           gap;	// Clocks since the last bit
	int           nb;	// Bits taken of the current group
	logic         run;	// Some bit has been seen
	logic [103:0] sh;	// First bit ends up on top

	// Take each bit, police spacing and framing
	always @(posedge clk) begin
		grp_done <= 1'b0;
		gap_bad  <= 1'b0;
		if (rst) begin
			gap <= 0;
			nb  <= 0;
			run <= 1'b0;
		end else if (rds_bit_valid) begin
			if (run && gap + 1 != BIT_CYCLES) gap_bad <= 1'b1;
			if (group_start !== (nb == 0)) gap_bad <= 1'b1;
			gap <= 0;
			run <= 1'b1;
			sh  <= {sh[102:0], rds_bit};
			nb  <= (nb == 103) ? 0 : nb + 1;
			if (nb == 103) begin
				grp_bits <= {sh[102:0], rds_bit};
				grp_done <= 1'b1;
			end
		end else begin
			gap <= gap + 1;	// Idle clock
		end
	end
endmodule : rdsga_modem_sink

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdsga_params.svh"

// ----------------------------------------------------------------------------
// Self-checking bench with a group model
// ----------------------------------------------------------------------------
module testbench;
	localparam int BC = 16;	// Short bit period
	logic          clk, rst, tx_enable, tp_flag, user_valid, user_list;
	logic [15:0]   pi_code, seq_slots;
	logic [4:0]    pty_code;
	logic [63:0]   ps_name;
	logic [47:0]   user_group;
	logic [1:0]    list_clear;
	wire logic     user_ready, rds_bit, rds_bit_valid, group_start, got_done, gap_bad;
	wire logic [103:0] got_grp;
	int            bad_count, samples_checked, cyc, slot, seg, i1, i2, n;
	logic [47:0]   l1[$], l2[$];	// Model copies of both lists
	logic [103:0]  exp_q[$];	// Groups expected on the wire
	logic [15:0]   tyw[6] = '{16'h5000, 16'h5800, 16'h6000, 16'h6800, 16'h3000, 16'hB000};
	logic [47:0]   e;

	rdsga_assembler #(.BIT_CYCLES(BC)) uut (.clk(clk), .rst(rst), .tx_enable(tx_enable),
		.pi_code(pi_code), .tp_flag(tp_flag), .pty_code(pty_code), .ps_name(ps_name),
		.seq_slots(seq_slots), .user_valid(user_valid), .user_ready(user_ready),
		.user_list(user_list), .user_group(user_group), .list_clear(list_clear),
		.rds_bit(rds_bit), .rds_bit_valid(rds_bit_valid), .group_start(group_start));
	rdsga_modem_sink #(.BIT_CYCLES(BC)) sink (.clk(clk), .rst(rst), .rds_bit(rds_bit),
		.rds_bit_valid(rds_bit_valid), .group_start(group_start), .grp_bits(got_grp),
		.grp_done(got_done), .gap_bad(gap_bad));

	// Checkword: info times x^10 modulo the generator
	function automatic logic [9:0] chk10(input logic [15:0] d);
		logic [9:0] r;
		logic       fb;
		r = '0;
		for (int i = 15; i >= 0; i--) begin
			fb = r[9] ^ d[i];
			r  = {r[8:0], 1'b0};
			if (fb) r = r ^ `RDSGA_POLY;
		end
		return r;
	endfunction : chk10

	// Next group from slot order, lists and name segment
	function automatic logic [103:0] next_group();
		logic [47:0] u;
		logic [15:0] b2, b3;
		logic [1:0]  sel;
		sel  = seq_slots[2*slot +: 2];
		slot = (slot + 1) % 8;
		if (sel == 2'h1 && l1.size() > 0) begin
			u  = l1[i1];
			i1 = (i1 + 1) % l1.size();
		end else if (sel == 2'h2 && l2.size() > 0) begin
			u  = l2[i2];
			i2 = (i2 + 1) % l2.size();
		end else begin
			u   = {16'(seg), 16'(`RDSGA_AF_FILL), ps_name[63-16*seg -: 16]};
			seg = (seg + 1) % 4;
		end
		b2 = u[47:32] | {5'h0, tp_flag, pty_code, 5'h0};
		b3 = u[43] ? pi_code : u[31:16];
		return {pi_code, chk10(pi_code) ^ `RDSGA_OFS_A, b2, chk10(b2) ^ `RDSGA_OFS_B,
			b3, chk10(b3) ^ (u[43] ? `RDSGA_OFS_CP : `RDSGA_OFS_C), u[15:0], chk10(u[15:0]) ^ `RDSGA_OFS_D};
	endfunction : next_group

	// Compare one whole group
	task automatic chk_grp(input string nm, input logic [103:0] ex, input logic [103:0] got);
		samples_checked++;
		if (got !== ex) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk_grp

	// Compare one flag
	task automatic chk_bit(input string nm, input logic ex, input logic got);
		samples_checked++;
		if (got !== ex) begin
			bad_count++;
			$display("FAIL %s expected %b seen %b", nm, ex, got);
		end
	endtask : chk_bit

	// Verdict and end of run
	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc >= 40000) begin
			bad_count++;
			finish_test();
		end
	end

	// Model step per group, compare per received group
	always @(posedge clk) begin
		if (!rst && group_start === 1'b1) exp_q.push_back(next_group());
		if (got_done === 1'b1) begin
			if (exp_q.size() == 0) chk_bit("unexpected_group", 1'b0, 1'b1);
			else chk_grp("group", exp_q.pop_front(), got_grp);
		end
		if (!rst) chk_bit("bit_spacing", 1'b0, gap_bad);
	end

	// Main sequence
	initial begin
		{rst, tx_enable, tp_flag, user_valid, user_list, list_clear} = 7'h40;
		{pi_code, seq_slots, pty_code, ps_name, user_group} = '0;
		n = $urandom(32'h9c45dd59);
		repeat (10) @(posedge clk);
		rst        <= 1'b0;
		seq_slots  <= (16'($urandom) & 16'hF000) | 16'h0179;
		// Fill the first list until the path refuses
		n = 0;
		for (int k = 0; k < 40 && n < 13; k++) begin
			@(posedge clk);
			if (user_valid && user_ready) n++;
			e = (n >= 8) ? {tyw[n-8] | 16'($urandom_range(31)), 16'($urandom), 16'($urandom)} : 48'($urandom);
			if (n >= 8 && n < 12) l1.push_back(e);	// Model keeps what lands after two clears
			user_valid <= (n < 12);
			user_group <= e;
			if (!user_ready && n == 12) k = 40;
		end
		l1 = l1[$-3:$];
		chk_bit("accepted_twelve", 1'b1, n == 12);
		repeat (3) @(posedge clk);
		chk_bit("ready_full", 1'b0, user_ready);
		repeat (2) begin
			list_clear <= 2'h1;
			@(posedge clk);
			list_clear <= 2'h0;
			repeat (20) @(posedge clk);
		end
		chk_bit("ready_drained", 1'b1, user_ready);
		// Second list: 3A and 11A entries
		for (int k = 4; k < 6; k++) begin
			e = {tyw[k] | 16'($urandom_range(31)), (k == 4) ? 16'h0 : 16'($urandom), 16'($urandom) | 16'h1};
			l2.push_back(e);
			user_valid <= 1'b1;
			user_list  <= 1'b1;
			user_group <= e;
			@(posedge clk iff user_ready);
			user_valid <= 1'b0;
			@(posedge clk);
		end
		repeat (5) @(posedge clk);
		tx_enable <= 1'b1;
		for (n = 0; n < 13; n++) begin
			@(posedge clk iff group_start);
			@(posedge clk);
			pi_code  <= 16'($urandom);
			tp_flag  <= 1'($urandom);
			pty_code <= 5'($urandom);
			ps_name  <= {$urandom, $urandom};
			if (n == 12) tx_enable <= 1'b0;
			if (n == 7) begin
				list_clear <= 2'h2;
				l2.delete();
				i2 = 0;
				@(posedge clk);
				list_clear <= 2'h0;
			end
		end
		@(posedge clk iff got_done);
		for (int k = 0; k < 30 * BC; k++) begin
			@(posedge clk);
			if (rds_bit !== 1'b0 || rds_bit_valid !== 1'b0) chk_bit("idle_line", 1'b0, 1'b1);
		end
		chk_bit("all_groups_seen", 1'b1, exp_q.size() == 0);
		finish_test();
	end
endmodule : testbench

`default_nettype wire
